// ===== rtc_pkg.sv
// constants for the alarm, clock output and countdown block
package rtc_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL2_ADDR    = 8'h01;
   localparam logic [7:0] MIN_ADDR      = 8'h09;
   localparam logic [7:0] HOUR_ADDR     = 8'h0a;
   localparam logic [7:0] DAY_ADDR      = 8'h0b;
   localparam logic [7:0] WDAY_ADDR     = 8'h0c;
   localparam logic [7:0] CLOCK_OUTPUT_PIN_ADDR   = 8'h0d;
   localparam logic [7:0] CDCTRL_ADDR   = 8'h0e;
   localparam logic [7:0] CDVAL_ADDR    = 8'h0f;

   // ----------------------------------------------------------------
   // field layouts
   // ----------------------------------------------------------------
   localparam int DIS_BIT               = 7;   // match disable, active high
   localparam logic [7:0] MIN_MASK      = 8'h7f;
   localparam logic [7:0] HOUR_MASK     = 8'h3f;
   localparam logic [7:0] DAY_MASK      = 8'h3f;
   localparam logic [7:0] WDAY_MASK     = 8'h07;
   localparam int EN_BIT                = 7;   // clock output enable / countdown run
   localparam int SEL_LSB               = 0;   // two-bit select fields at 1:0
   // control register two
   localparam int C2_CD_IE              = 0;
   localparam int C2_AL_IE              = 1;
   localparam int C2_CD_FLAG            = 2;
   localparam int C2_AL_FLAG            = 3;
   localparam int C2_PULSE              = 4;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] MATCH_RST     = 8'h80;
   localparam logic [7:0] CLOCK_OUTPUT_PIN_RST    = 8'h80;
   localparam logic [7:0] CDCTRL_RST    = 8'h03;
   localparam logic [7:0] CDVAL_RST     = 8'h00;
   localparam logic [7:0] CTRL2_RST     = 8'h00;

   // ----------------------------------------------------------------
   // prescaler tap positions and timing
   // ----------------------------------------------------------------
   localparam int TAP_32K               = 0;
   localparam int TAP_1K                = 1;
   localparam int TAP_32                = 2;
   localparam int TAP_1                 = 3;
   localparam int TAP_4K                = 4;
   localparam int TAP_64                = 5;
   localparam int TAP_N                 = 6;
   localparam logic [5:0] SIXTY_M1      = 6'h3b; // 1 Hz ticks per 1/60 Hz tick, less one
   localparam int CLK_NS                = 40;
   localparam int PULSE_NS              = 15625000; // countdown pulse width, 1/64 s
   localparam int PULSE_CYC             = PULSE_NS / CLK_NS;

endpackage

// ===== rtc_tap_sync.sv
// two-flop synchroniser with rising-edge pulse for prescaler taps
`timescale 1ns/1ps
module rtc_tap_sync #(
   parameter int WIDTH = 6
) (
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] tap_async,
   output logic      [WIDTH-1:0] tap_level,
   output logic      [WIDTH-1:0] tap_rise
);

   // ----------------------------------------------------------------
   // synchroniser
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] last;

   // only the second stage and later are ever looked at
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         meta      <= '0;
         tap_level <= '0;
         last      <= '0;
      end else begin
         meta      <= tap_async;
         tap_level <= meta;
         last      <= tap_level;
      end
   end

   assign tap_rise = tap_level & ~last;

endmodule

// ===== rtc_alarm_timer_clock_output_pin.sv
// alarm compare, clock output select and countdown timer with register port
`timescale 1ns/1ps
module rtc_alarm_timer_clock_output_pin #(
   parameter int PULSE_CYCLES = rtc_pkg::PULSE_CYC
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   // register port from the serial interface
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // current time from the time counters, same clock
   input  wire logic [7:0]  cur_minute,
   input  wire logic [7:0]  cur_hour,
   input  wire logic [7:0]  cur_day,
   input  wire logic [7:0]  cur_weekday,
   // prescaler taps from the crystal domain
   input  wire logic [5:0]  prescale_tap,
   // pins
   output logic             clock_output_pin,
   output logic             irq_o,
   output logic             irq_oe
);

   // ----------------------------------------------------------------
   // tap synchronisation
   // ----------------------------------------------------------------
   logic [rtc_pkg::TAP_N-1:0] tap_level;
   logic [rtc_pkg::TAP_N-1:0] tap_rise;

   rtc_tap_sync #(
      .WIDTH     (rtc_pkg::TAP_N)
   ) u_sync (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .tap_async (prescale_tap),
      .tap_level (tap_level),
      .tap_rise  (tap_rise)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  minute_match,  next_minute_match;
   logic [7:0]  hour_match,    next_hour_match;
   logic [7:0]  day_match,     next_day_match;
   logic [7:0]  weekday_match, next_weekday_match;
   logic [7:0]  clock_output_control, next_clock_output_control;
   logic [7:0]  countdown_control,    next_countdown_control;
   logic [7:0]  countdown_reload,     next_countdown_reload;
   logic [7:0]  countdown_count,      next_countdown_count;
   logic        alarm_flag,    next_alarm_flag;
   logic        countdown_flag, next_countdown_flag;
   logic        alarm_irq_enable, next_alarm_irq_enable;
   logic        countdown_irq_enable, next_countdown_irq_enable;
   logic        countdown_irq_pulse_mode, next_countdown_irq_pulse_mode;
   logic        match_q,       next_match_q;
   logic [5:0]  sixty_cnt,     next_sixty_cnt;
   logic [31:0] pulse_cnt,     next_pulse_cnt;
   logic [7:0]  next_reg_rdata;
   logic        next_clock_output_pin;
   logic        next_irq_oe;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // one compare used for all four match registers
   function automatic logic field_ok(input logic [7:0] mreg, input logic [7:0] cur,
                                     input logic [7:0] mask);
      field_ok = mreg[rtc_pkg::DIS_BIT] || ((mreg & mask) == (cur & mask));
   endfunction

   // select one of four taps by a two-bit field
   function automatic logic pick4(input logic [1:0] sel, input logic a, input logic b,
                                  input logic c, input logic d);
      case (sel)
         2'h0:    pick4 = a;
         2'h1:    pick4 = b;
         2'h2:    pick4 = c;
         default: pick4 = d;
      endcase
   endfunction

   logic any_enabled;
   logic match_now;
   logic alarm_set;
   logic sixty_tick;
   logic cd_tick;
   logic cd_end;
   logic wr_ctrl2;

   // alarm compare: all enabled fields equal, at least one enabled
   assign any_enabled = ~(minute_match[rtc_pkg::DIS_BIT] & hour_match[rtc_pkg::DIS_BIT]
                        & day_match[rtc_pkg::DIS_BIT] & weekday_match[rtc_pkg::DIS_BIT]);
   assign match_now   = any_enabled
                        & field_ok(minute_match,  cur_minute,  rtc_pkg::MIN_MASK)
                        & field_ok(hour_match,    cur_hour,    rtc_pkg::HOUR_MASK)
                        & field_ok(day_match,     cur_day,     rtc_pkg::DAY_MASK)
                        & field_ok(weekday_match, cur_weekday, rtc_pkg::WDAY_MASK);
   // only the entry into a match sets the flag, so a cleared flag stays clear
   assign alarm_set   = match_now & ~match_q;

   // source tick for the countdown; 1/60 Hz is cut from the 1 Hz tap
   assign sixty_tick  = tap_rise[rtc_pkg::TAP_1] && (sixty_cnt == rtc_pkg::SIXTY_M1);
   assign cd_tick     = countdown_control[rtc_pkg::EN_BIT]
                        & pick4(countdown_control[rtc_pkg::SEL_LSB +: 2],
                                tap_rise[rtc_pkg::TAP_4K], tap_rise[rtc_pkg::TAP_64],
                                tap_rise[rtc_pkg::TAP_1], sixty_tick);
   // a reload of zero never ends a countdown
   assign cd_end      = cd_tick && (countdown_reload != 8'h00)
                        && (countdown_count <= 8'h01);
   assign wr_ctrl2    = reg_wr && (reg_addr == rtc_pkg::CTRL2_ADDR);

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      next_minute_match             = minute_match;
      next_hour_match               = hour_match;
      next_day_match                = day_match;
      next_weekday_match            = weekday_match;
      next_clock_output_control     = clock_output_control;
      next_countdown_control        = countdown_control;
      next_countdown_reload         = countdown_reload;
      next_countdown_count          = countdown_count;
      next_alarm_irq_enable         = alarm_irq_enable;
      next_countdown_irq_enable     = countdown_irq_enable;
      next_countdown_irq_pulse_mode = countdown_irq_pulse_mode;
      next_match_q                  = match_now;
      next_sixty_cnt                = sixty_cnt;
      next_pulse_cnt                = pulse_cnt;
      next_reg_rdata                = reg_rdata;

      // 1/60 Hz divider
      if (tap_rise[rtc_pkg::TAP_1]) begin
         next_sixty_cnt = sixty_tick ? 6'h00 : sixty_cnt + 6'h01;
      end

      // countdown: reload at the end of each period
      if (cd_tick) begin
         if (countdown_count <= 8'h01) begin
            next_countdown_count = countdown_reload;
         end else begin
            next_countdown_count = countdown_count - 8'h01;
         end
      end

      // pulse stretcher for pulse mode
      if (cd_end) begin
         next_pulse_cnt = 32'(PULSE_CYCLES);
      end else if (pulse_cnt != 32'h0) begin
         next_pulse_cnt = pulse_cnt - 32'h1;
      end

      // register writes; only defined bits are stored
      if (reg_wr) begin
         case (reg_addr)
            rtc_pkg::MIN_ADDR:    next_minute_match  = reg_wdata & (rtc_pkg::MIN_MASK | 8'h80);
            rtc_pkg::HOUR_ADDR:   next_hour_match    = reg_wdata & (rtc_pkg::HOUR_MASK | 8'h80);
            rtc_pkg::DAY_ADDR:    next_day_match     = reg_wdata & (rtc_pkg::DAY_MASK | 8'h80);
            rtc_pkg::WDAY_ADDR:   next_weekday_match = reg_wdata & (rtc_pkg::WDAY_MASK | 8'h80);
            rtc_pkg::CLOCK_OUTPUT_PIN_ADDR: next_clock_output_control = reg_wdata & 8'h83;
            rtc_pkg::CDCTRL_ADDR: next_countdown_control    = reg_wdata & 8'h83;
            rtc_pkg::CDVAL_ADDR: begin
               next_countdown_reload = reg_wdata;
               next_countdown_count  = reg_wdata;
            end
            rtc_pkg::CTRL2_ADDR: begin
               next_alarm_irq_enable         = reg_wdata[rtc_pkg::C2_AL_IE];
               next_countdown_irq_enable     = reg_wdata[rtc_pkg::C2_CD_IE];
               next_countdown_irq_pulse_mode = reg_wdata[rtc_pkg::C2_PULSE];
            end
            default: ;
         endcase
      end

      // flags: write 0 clears, write 1 keeps; a set in the same cycle wins
      next_alarm_flag = alarm_set | (alarm_flag
                        & ~(wr_ctrl2 & ~reg_wdata[rtc_pkg::C2_AL_FLAG]));
      next_countdown_flag = cd_end | (countdown_flag
                        & ~(wr_ctrl2 & ~reg_wdata[rtc_pkg::C2_CD_FLAG]));

      // read data, registered; unmapped offsets read zero
      if (reg_rd) begin
         case (reg_addr)
            rtc_pkg::MIN_ADDR:    next_reg_rdata = minute_match;
            rtc_pkg::HOUR_ADDR:   next_reg_rdata = hour_match;
            rtc_pkg::DAY_ADDR:    next_reg_rdata = day_match;
            rtc_pkg::WDAY_ADDR:   next_reg_rdata = weekday_match;
            rtc_pkg::CLOCK_OUTPUT_PIN_ADDR: next_reg_rdata = clock_output_control;
            rtc_pkg::CDCTRL_ADDR: next_reg_rdata = countdown_control;
            rtc_pkg::CDVAL_ADDR:  next_reg_rdata = countdown_count;
            rtc_pkg::CTRL2_ADDR: begin
               next_reg_rdata = 8'h00;
               next_reg_rdata[rtc_pkg::C2_CD_IE]   = countdown_irq_enable;
               next_reg_rdata[rtc_pkg::C2_AL_IE]   = alarm_irq_enable;
               next_reg_rdata[rtc_pkg::C2_CD_FLAG] = countdown_flag;
               next_reg_rdata[rtc_pkg::C2_AL_FLAG] = alarm_flag;
               next_reg_rdata[rtc_pkg::C2_PULSE]   = countdown_irq_pulse_mode;
            end
            default: next_reg_rdata = 8'h00;
         endcase
      end

      // clock output: selected tap level, held low when inhibited
      next_clock_output_pin = clock_output_control[rtc_pkg::EN_BIT]
                              & pick4(clock_output_control[rtc_pkg::SEL_LSB +: 2],
                                      tap_level[rtc_pkg::TAP_32K], tap_level[rtc_pkg::TAP_1K],
                                      tap_level[rtc_pkg::TAP_32], tap_level[rtc_pkg::TAP_1]);

      // open-drain interrupt: pull low while any enabled source is active
      next_irq_oe = (alarm_irq_enable & next_alarm_flag)
                    | (countdown_irq_enable & (countdown_irq_pulse_mode
                       ? (next_pulse_cnt != 32'h0) : next_countdown_flag));
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         minute_match             <= rtc_pkg::MATCH_RST;
         hour_match               <= rtc_pkg::MATCH_RST;
         day_match                <= rtc_pkg::MATCH_RST;
         weekday_match            <= rtc_pkg::MATCH_RST;
         clock_output_control     <= rtc_pkg::CLOCK_OUTPUT_PIN_RST;
         countdown_control        <= rtc_pkg::CDCTRL_RST;
         countdown_reload         <= rtc_pkg::CDVAL_RST;
         countdown_count          <= rtc_pkg::CDVAL_RST;
         alarm_flag               <= 1'b0;
         countdown_flag           <= 1'b0;
         alarm_irq_enable         <= 1'b0;
         countdown_irq_enable     <= 1'b0;
         countdown_irq_pulse_mode <= 1'b0;
         match_q                  <= 1'b0;
         sixty_cnt                <= 6'h00;
         pulse_cnt                <= 32'h0;
         reg_rdata                <= 8'h00;
         clock_output_pin         <= 1'b0;
         irq_oe                   <= 1'b0;
         irq_o                    <= 1'b0;
      end else begin
         minute_match             <= next_minute_match;
         hour_match               <= next_hour_match;
         day_match                <= next_day_match;
         weekday_match            <= next_weekday_match;
         clock_output_control     <= next_clock_output_control;
         countdown_control        <= next_countdown_control;
         countdown_reload         <= next_countdown_reload;
         countdown_count          <= next_countdown_count;
         alarm_flag               <= next_alarm_flag;
         countdown_flag           <= next_countdown_flag;
         alarm_irq_enable         <= next_alarm_irq_enable;
         countdown_irq_enable     <= next_countdown_irq_enable;
         countdown_irq_pulse_mode <= next_countdown_irq_pulse_mode;
         match_q                  <= next_match_q;
         sixty_cnt                <= next_sixty_cnt;
         pulse_cnt                <= next_pulse_cnt;
         reg_rdata                <= next_reg_rdata;
         clock_output_pin         <= next_clock_output_pin;
         irq_oe                   <= next_irq_oe;
         irq_o                    <= 1'b0; // open drain only ever drives low
      end
   end

endmodule

// ===== rtc_monitor.sv
// concurrent checks on the ports of the alarm, clock output and countdown block
`timescale 1ns/1ps
module rtc_monitor #(
   parameter int PULSE_CYCLES = 4
) (
   input wire logic       mclk,
   input wire logic       sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       clock_output_pin,
   input wire logic       irq_o,
   input wire logic       irq_oe
);
   logic [7:0] sh_min, sh_wday, sh_co, sh_cd, sh_c2;
   int         hi_cnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // shadow of host writes; flags set by hardware are not tracked here
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sh_min  <= 8'h80;
         sh_wday <= 8'h80;
         sh_co   <= 8'h80;
         sh_cd   <= 8'h03;
         sh_c2   <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            rtc_pkg::MIN_ADDR:    sh_min <= reg_wdata;
            rtc_pkg::WDAY_ADDR:   sh_wday <= reg_wdata;
            rtc_pkg::CLOCK_OUTPUT_PIN_ADDR: sh_co <= reg_wdata;
            rtc_pkg::CDCTRL_ADDR: sh_cd <= reg_wdata;
            rtc_pkg::CTRL2_ADDR:  sh_c2 <= reg_wdata;
            default: ;
         endcase
      end
   end
   // length of the running interrupt assertion; a mode write restarts it
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst)
         hi_cnt <= 0;
      else if (!irq_oe || (reg_wr && reg_addr == rtc_pkg::CTRL2_ADDR))
         hi_cnt <= 0;
      else
         hi_cnt <= hi_cnt + 1;
   end
   minute_read_a: assert property (reg_rd && reg_addr == rtc_pkg::MIN_ADDR |=> reg_rdata == sh_min)
      else $error("minute match readback wrong");
   weekday_read_a: assert property (reg_rd && reg_addr == rtc_pkg::WDAY_ADDR |=> reg_rdata == (sh_wday & 8'h87))
      else $error("weekday match readback wrong");
   clock_output_pin_read_a: assert property (reg_rd && reg_addr == rtc_pkg::CLOCK_OUTPUT_PIN_ADDR |=> reg_rdata == (sh_co & 8'h83))
      else $error("clock output control readback wrong");
   cdctrl_read_a: assert property (reg_rd && reg_addr == rtc_pkg::CDCTRL_ADDR |=> reg_rdata == (sh_cd & 8'h83))
      else $error("countdown control readback wrong");
   clock_output_pin_low_a: assert property ((!sh_co[7])[*5] |-> !clock_output_pin)
      else $error("clock output not held low while disabled");
   pulse_width_a: assert property (irq_oe && sh_c2[4] && !sh_c2[1] |-> hi_cnt < PULSE_CYCLES)
      else $error("countdown pulse too long");
   rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   irq_level_a: assert property (irq_o == 1'b0)
      else $error("interrupt pin driven high");
endmodule
bind rtc_alarm_timer_clock_output_pin rtc_monitor #(.PULSE_CYCLES(PULSE_CYCLES)) rtc_monitor_inst (
   .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .clock_output_pin(clock_output_pin), .irq_o(irq_o), .irq_oe(irq_oe));

// ===== rtc_host_model.sv
// host model: byte accesses on the register port as the serial interface makes them
`timescale 1ns/1ps
module rtc_host_model (
   input  wire logic       mclk,
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd
);
   // idle port at time zero
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end
   // one byte write, held across one sampling edge; data inverted after release
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // one byte read; data is registered on the sampling edge
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   // live count is not frozen, so read pairs until two agree, at most four pairs
   task automatic read_count(output logic [7:0] d);
      logic [7:0] d2;
      d2 = 8'h00;
      d  = 8'h01;
      for (int i = 0; i < 4 && d !== d2; i++) begin
         read_reg(rtc_pkg::CDVAL_ADDR, d);
         read_reg(rtc_pkg::CDVAL_ADDR, d2);
      end
   endtask
   // unused countdown parked on the slowest source to save power
   task automatic park_countdown;
      write_reg(rtc_pkg::CDCTRL_ADDR, 8'h03);
   endtask
endmodule

// ===== tb_rtc_alarm_timer_clock_output_pin.sv
// self-checking bench for the alarm, clock output and countdown block
`timescale 1ns/1ps
module tb_rtc_alarm_timer_clock_output_pin;
   localparam int PULSE = 4;
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, div = 8'h00;
   logic       reg_wr, reg_rd, clock_output_pin, irq_o, irq_oe;
   logic [7:0] cur_minute = 8'h30, cur_hour = 8'h08, cur_day = 8'h15, cur_weekday = 8'h03;
   logic [5:0] prescale_tap = 6'h00;
   int         comparisons = 0;
   int         miscompares = 0;
   rtc_alarm_timer_clock_output_pin #(.PULSE_CYCLES(PULSE)) rtc_alarm_timer_clock_output_pin_inst (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cur_minute(cur_minute), .cur_hour(cur_hour), .cur_day(cur_day),
      .cur_weekday(cur_weekday), .prescale_tap(prescale_tap),
      .clock_output_pin(clock_output_pin), .irq_o(irq_o), .irq_oe(irq_oe));
   rtc_host_model rtc_host_model_inst (
      .mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd));
   // 40 ns clock
   always #20 mclk = ~mclk;
   // scaled prescaler: tap half periods 2,8,32,128 (clock out) and 4,16 (countdown)
   always @(posedge mclk) begin
      div          <= div + 8'h01;
      prescale_tap <= {div[4], div[2], div[7], div[5], div[3], div[1]};
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // reset values, unused bits, unmapped offset
   task automatic test_regs;
      logic [7:0] v;
      logic [7:0] adr [9] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h01, 8'h10};
      logic [7:0] rv [9] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03, 8'h00, 8'h00, 8'h00};
      logic [7:0] msk [4] = '{8'hff, 8'hbf, 8'hbf, 8'h87};
      for (int i = 0; i < 9; i++) begin
         rtc_host_model_inst.read_reg(adr[i], v);
         check("reset value", v, rv[i]);
      end
      for (int i = 0; i < 4; i++) begin
         rtc_host_model_inst.write_reg(adr[i], 8'hff);
         rtc_host_model_inst.read_reg(adr[i], v);
         check("match bits", v, msk[i]);
         rtc_host_model_inst.write_reg(adr[i], 8'h80);
      end
      rtc_host_model_inst.write_reg(8'h10, 8'h55);
      rtc_host_model_inst.read_reg(8'h10, v);
      check("unmapped", v, 8'h00);
   endtask
   // leave the matching minute and come back into it
   task automatic step_minute;
      @(posedge mclk);
      cur_minute <= 8'h31;
      repeat (3) @(posedge mclk);
      cur_minute <= 8'h30;
      repeat (3) @(posedge mclk);
   endtask
   // minute enabled, hour disabled with a differing value
   task automatic test_alarm;
      logic [7:0] v;
      rtc_host_model_inst.write_reg(rtc_pkg::CTRL2_ADDR, 8'h02);
      rtc_host_model_inst.write_reg(rtc_pkg::HOUR_ADDR, 8'h89);
      rtc_host_model_inst.write_reg(rtc_pkg::MIN_ADDR, 8'h30);
      repeat (3) @(posedge mclk);
      rtc_host_model_inst.read_reg(rtc_pkg::CTRL2_ADDR, v);
      check("alarm set", v, 8'h0a);
      check("alarm irq", {7'h00, irq_oe}, 8'h01);
      rtc_host_model_inst.write_reg(rtc_pkg::CTRL2_ADDR, 8'h02);
      repeat (3) @(posedge mclk);
      rtc_host_model_inst.read_reg(rtc_pkg::CTRL2_ADDR, v);
      check("alarm cleared", v, 8'h02);
      check("alarm irq off", {7'h00, irq_oe}, 8'h00);
      step_minute;
      rtc_host_model_inst.read_reg(rtc_pkg::CTRL2_ADDR, v);
      check("alarm again", v, 8'h0a);
      rtc_host_model_inst.write_reg(rtc_pkg::MIN_ADDR, 8'hb0);
      rtc_host_model_inst.write_reg(rtc_pkg::CTRL2_ADDR, 8'h02);
      step_minute;
      rtc_host_model_inst.read_reg(rtc_pkg::CTRL2_ADDR, v);
      check("alarm all off", v, 8'h02);
   endtask
   // edges of the clock output over 512 cycles
   task automatic count_edges(output int n);
      logic last;
      n    = 0;
      last = clock_output_pin;
      repeat (512) begin
         @(posedge mclk);
         #1;
         if (clock_output_pin !== last)
            n++;
         last = clock_output_pin;
      end
   endtask
   task automatic test_clock_output_pin;
      int n;
      int half [4] = '{2, 8, 32, 128};
      for (int s = 0; s < 4; s++) begin
         rtc_host_model_inst.write_reg(rtc_pkg::CLOCK_OUTPUT_PIN_ADDR, {6'h20, s[1:0]});
         repeat (8) @(posedge mclk);
         count_edges(n);
         check("clock_output_pin rate", 8'(n >= 512 / half[s] - 1 && n <= 512 / half[s] + 1), 8'h01);
      end
      rtc_host_model_inst.write_reg(rtc_pkg::CLOCK_OUTPUT_PIN_ADDR, 8'h00);
      repeat (8) @(posedge mclk);
      count_edges(n);
      check("clock_output_pin off", {7'(n), clock_output_pin}, 8'h00);
   endtask
   // n = 3 on the fastest source (8 cycles a tick), level then pulse mode
   task automatic test_countdown;
      logic [7:0] v;
      int t;
      rtc_host_model_inst.write_reg(rtc_pkg::CTRL2_ADDR, 8'h01);
      rtc_host_model_inst.write_reg(rtc_pkg::CDVAL_ADDR, 8'h03);
      rtc_host_model_inst.write_reg(rtc_pkg::CDCTRL_ADDR, 8'h80);
      for (t = 0; irq_oe !== 1'b1 && t < 100; t++) @(posedge mclk);
      check("period", 8'(t >= 17 && t <= 31), 8'h01);
      rtc_host_model_inst.read_reg(rtc_pkg::CTRL2_ADDR, v);
      check("cd flag", v, 8'h05);
      rtc_host_model_inst.read_count(v);
      check("live count", 8'(v >= 8'h01 && v <= 8'h03), 8'h01);
      check("level irq", {7'h00, irq_oe}, 8'h01);
      rtc_host_model_inst.write_reg(rtc_pkg::CTRL2_ADDR, 8'h11);
      repeat (2) @(posedge mclk);
      for (t = 0; irq_oe !== 1'b1 && t < 60; t++) @(posedge mclk);
      for (t = 0; irq_oe === 1'b1 && t < 20; t++) @(posedge mclk);
      check("pulse width", 8'(t), 8'(PULSE));
      rtc_host_model_inst.read_reg(rtc_pkg::CTRL2_ADDR, v);
      check("flag each end", v, 8'h15);
      rtc_host_model_inst.park_countdown;
      rtc_host_model_inst.read_reg(rtc_pkg::CDCTRL_ADDR, v);
      check("parked", v, 8'h03);
   endtask
   // watchdog, far beyond the roughly 2800 cycles the tests take
   initial begin
      repeat (30000) @(posedge mclk);
      miscompares++;
      conclude;
   end
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      test_regs;
      test_alarm;
      test_clock_output_pin;
      test_countdown;
      conclude;
   end
endmodule
